// *** verilog/cbt_transceiver.sv ***
`timescale 1ns/1ns

// ****************************************************************************
// cpu side serial bus transceiver, master clock domain
// ****************************************************************************
module cbt_transceiver
    import cbt_pkg::*;
(
    // master clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // clear and direction from the cpu
    input  wire logic clear_n,
    input  wire logic dir_select,
    output logic      dir_select_n,
    // cpu serial lane a
    input  wire logic cpu_serial_lane_a_in,
    output logic      cpu_serial_lane_a_out,
    output logic      cpu_serial_lane_a_oe,
    // cpu serial lane b
    input  wire logic cpu_serial_lane_b_in,
    output logic      cpu_serial_lane_b_out,
    output logic      cpu_serial_lane_b_oe,
    // cpu transfer clock
    input  wire logic cpu_xfer_clk_in,
    output logic      cpu_xfer_clk_out,
    output logic      cpu_xfer_clk_oe,
    // phase clocks to the cpu clock driver
    output logic      phase_a,
    output logic      phase_b,
    // forwarded master clock
    output logic      bus_master_clock_pair_out,
    output logic      bus_master_clock_pair_oe,
    // bus lane a
    input  wire logic bus_lane_a_pair_in,
    output logic      bus_lane_a_pair_out,
    output logic      bus_lane_a_pair_oe,
    // bus lane b
    input  wire logic bus_lane_b_pair_in,
    output logic      bus_lane_b_pair_out,
    output logic      bus_lane_b_pair_oe,
    // bus transfer clock: incoming transitions arrive as the shift clock
    input  wire logic bus_shift_clk,
    output logic      bus_transfer_clock_pair_out,
    output logic      bus_transfer_clock_pair_oe
);

    // ************************************************************************
    // state of the master clock domain
    // ************************************************************************
    typedef struct packed {
        logic [1:0]    cnt;        // phase counter
        logic          mclk;       // forwarded master clock
        logic          mclk_oe;    // forwarded clock enable
        logic          ph_a;       // phase a
        logic          ph_b;       // phase b
        logic          dir_s1;     // direction sync first stage
        logic          dir_s2;     // direction sync second stage
        logic          dir_n;      // inverted direction output
        logic          clr_s1;     // clear sync first stage
        logic          clr_s2;     // clear sync second stage
        logic          txa_s1;     // cpu lane a sync first stage
        logic          txa_s2;     // cpu lane a sync second stage
        logic          txb_s1;     // cpu lane b sync first stage
        logic          txb_s2;     // cpu lane b sync second stage
        logic          txc_s1;     // cpu clock sync first stage
        logic          txc_s2;     // cpu clock sync second stage
        logic          rxa_s1;     // received lane a first stage
        logic          rxa_s2;     // received lane a second stage
        logic          rxb_s1;     // received lane b first stage
        logic          rxb_s2;     // received lane b second stage
        logic          rxg_s1;     // received gate first stage
        logic          rxg_s2;     // received gate second stage
        cbt_mode_type  mode;       // direction latch
        logic          lane_a;     // transmit lane a flop
        logic          lane_b;     // transmit lane b flop
        logic          gate;       // transmit gate flop
        logic          bus_clk;    // bus transfer clock drive
        logic          bus_oe;     // bus drivers enable
        logic          cpu_a;      // cpu lane a drive
        logic          cpu_b;      // cpu lane b drive
        logic          cpu_clk;    // cpu clock drive
        logic          cpu_oe;     // cpu pin drivers enable
        cbt_guard_type guard;      // spurious edge guard
        logic          gate_clr;   // clears the link side gate flop
        logic          rx_hold;    // holds the link side in reset
    } cbt_main_type;

    cbt_main_type r;               // registered state
    cbt_main_type next_r;          // next state
    logic         rx_lane_a;       // link lane a flop
    logic         rx_lane_b;       // link lane b flop
    logic         rx_gate;         // link gate flop
    logic         link_rst_n;      // link side reset
    logic         mclk_rise;       // master clock rises this cycle
    logic         ph_b_fall;       // phase b falls this cycle
    logic         ph_b_high;       // phase b is high now

    // ************************************************************************
    // slot decode shared by the phase logic
    // ************************************************************************
    function automatic logic in_slot(input logic [1:0] cnt, input logic [1:0] slot);
        in_slot = (cnt == slot);
    endfunction : in_slot

    // ************************************************************************
    // link side receive flops
    // ************************************************************************
    // link side is held in reset outside receive, on clear, and by the guard
    assign link_rst_n = arst_n & ~r.rx_hold;

    cbt_link_rx u_link_rx (
        .bus_shift_clk       (bus_shift_clk),
        .rst_n               (link_rst_n),
        .bus_lane_a_in       (bus_lane_a_pair_in),
        .bus_lane_b_in       (bus_lane_b_pair_in),
        .lane_a_flop         (rx_lane_a),
        .lane_b_flop         (rx_lane_b),
        .bus_clock_gate_flop (rx_gate)
    );

    // ************************************************************************
    // edge events of the derived clocks
    // ************************************************************************
    always_comb begin
        // master clock rises when the counter leaves an even slot
        mclk_rise = ~r.cnt[CBT_MCLK_BIT];
        // phase b falls when its slot ends
        ph_b_fall = in_slot(r.cnt, CBT_PH_B_SLOT);
        // phase b output level as registered
        ph_b_high = r.ph_b;
    end

    // ************************************************************************
    // next state of the master clock domain
    // ************************************************************************
    always_comb begin
        next_r = r;

        // clock generation runs free
        next_r.cnt     = r.cnt + CBT_CNT_STEP;
        next_r.mclk    = next_r.cnt[CBT_MCLK_BIT];
        next_r.mclk_oe = 1'h1;
        next_r.ph_a    = in_slot(next_r.cnt, CBT_PH_A_SLOT);
        next_r.ph_b    = in_slot(next_r.cnt, CBT_PH_B_SLOT);

        // pin synchronisers, first stage feeds only the second
        next_r.dir_s1 = dir_select;
        next_r.dir_s2 = r.dir_s1;
        next_r.clr_s1 = clear_n;
        next_r.clr_s2 = r.clr_s1;
        next_r.txa_s1 = cpu_serial_lane_a_in;
        next_r.txa_s2 = r.txa_s1;
        next_r.txb_s1 = cpu_serial_lane_b_in;
        next_r.txb_s2 = r.txb_s1;
        next_r.txc_s1 = cpu_xfer_clk_in;
        next_r.txc_s2 = r.txc_s1;

        // link domain levels crossing in
        next_r.rxa_s1 = rx_lane_a;
        next_r.rxa_s2 = r.rxa_s1;
        next_r.rxb_s1 = rx_lane_b;
        next_r.rxb_s2 = r.rxb_s1;
        next_r.rxg_s1 = rx_gate;
        next_r.rxg_s2 = r.rxg_s1;

        // inverted direction output
        next_r.dir_n = ~r.dir_s2;

        // direction latch
        if (r.dir_s2) begin
            // receive: latch stays reset
            next_r.mode = CBT_RECEIVE;
        end else if (mclk_rise) begin
            // transmit: latch sets on the next master rise
            next_r.mode = CBT_TRANSMIT;
        end

        // transmit shift: master rising edges clock the lane flops
        if (r.mode == CBT_TRANSMIT) begin
            if (mclk_rise) begin
                next_r.lane_a = r.txa_s2;
                next_r.lane_b = r.txb_s2;
                // gate sets once the cpu clock starts and holds to the end
                if (r.txc_s2) begin
                    next_r.gate = 1'h1;
                end
            end
        end else begin
            // receive: transmit flops rest idle
            next_r.lane_a = CBT_LANE_IDLE;
            next_r.lane_b = CBT_LANE_IDLE;
            next_r.gate   = CBT_GATE_IDLE;
        end

        // gated shift clock on the bus, two edges per master clock period
        next_r.bus_clk = next_r.gate & next_r.mclk;
        next_r.bus_oe  = (next_r.mode == CBT_TRANSMIT);

        // cpu side pins
        next_r.cpu_oe  = (next_r.mode == CBT_RECEIVE);
        next_r.cpu_a   = r.rxa_s2;
        next_r.cpu_b   = r.rxb_s2;
        // inverted gate forms the cpu clock; clear pulls it low
        next_r.cpu_clk = ~r.rxg_s2 & r.clr_s2;

        // spurious edge guard in receive mode
        next_r.gate_clr = r.gate_clr;
        unique case (r.guard)
            CBT_GUARD_IDLE: begin
                // a gate seen set at a master rise arms the guard
                if (r.rxg_s2 && mclk_rise && (r.mode == CBT_RECEIVE)) begin
                    next_r.guard = CBT_GUARD_ARMED;
                end
            end
            CBT_GUARD_ARMED: begin
                if (!r.rxg_s2) begin
                    // second transition came in time: normal pair
                    next_r.guard = CBT_GUARD_IDLE;
                end else if (ph_b_fall) begin
                    // still set at the falling phase b edge: reset flop sets
                    next_r.guard = CBT_GUARD_FIRED;
                end
            end
            CBT_GUARD_FIRED: begin
                // clear the gate while phase b is high
                if (ph_b_high) begin
                    next_r.gate_clr = 1'h1;
                    next_r.guard    = CBT_GUARD_RELEASE;
                end
            end
            CBT_GUARD_RELEASE: begin
                // clear signals return idle on the next falling phase b
                if (ph_b_fall) begin
                    next_r.gate_clr = 1'h0;
                    next_r.guard    = CBT_GUARD_IDLE;
                end
            end
        endcase

        // link side reset outside receive, during clear, or on guard clear
        next_r.rx_hold = (next_r.mode == CBT_TRANSMIT) | ~r.clr_s2 | next_r.gate_clr;

        // clear resets the transfer path flops except the synchronisers and the cpu lane a and b drives
        if (!r.clr_s2) begin
            next_r.mode     = CBT_RECEIVE;
            next_r.lane_a   = CBT_LANE_IDLE;
            next_r.lane_b   = CBT_LANE_IDLE;
            next_r.gate     = CBT_GATE_IDLE;
            next_r.bus_clk  = 1'h0;
            next_r.bus_oe   = 1'h0;
            next_r.guard    = CBT_GUARD_IDLE;
            next_r.gate_clr = 1'h0;
            // cpu clock is only driven low when the pins face the cpu
            next_r.cpu_oe   = r.dir_s2;
            next_r.cpu_clk  = 1'h0;
        end
    end

    // ************************************************************************
    // register the whole state
    // ************************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r          <= '0;
            r.mclk_oe  <= 1'h1;
            r.dir_s1   <= CBT_DIR_RESET;
            r.dir_s2   <= CBT_DIR_RESET;
            r.clr_s1   <= CBT_CLR_RESET;
            r.clr_s2   <= CBT_CLR_RESET;
            r.ph_a     <= 1'h1;
            r.mode     <= CBT_RECEIVE;
            r.guard    <= CBT_GUARD_IDLE;
            r.cpu_oe   <= 1'h1;
            r.rx_hold  <= 1'h1;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************************
    // outputs straight from flops
    // ************************************************************************
    assign dir_select_n                = r.dir_n;
    assign cpu_serial_lane_a_out       = r.cpu_a;
    assign cpu_serial_lane_a_oe        = r.cpu_oe;
    assign cpu_serial_lane_b_out       = r.cpu_b;
    assign cpu_serial_lane_b_oe        = r.cpu_oe;
    assign cpu_xfer_clk_out            = r.cpu_clk;
    assign cpu_xfer_clk_oe             = r.cpu_oe;
    assign phase_a                     = r.ph_a;
    assign phase_b                     = r.ph_b;
    assign bus_master_clock_pair_out   = r.mclk;
    assign bus_master_clock_pair_oe    = r.mclk_oe;
    assign bus_lane_a_pair_out         = r.lane_a;
    assign bus_lane_a_pair_oe          = r.bus_oe;
    assign bus_lane_b_pair_out         = r.lane_b;
    assign bus_lane_b_pair_oe          = r.bus_oe;
    assign bus_transfer_clock_pair_out = r.bus_clk;
    assign bus_transfer_clock_pair_oe  = r.bus_oe;

endmodule : cbt_transceiver

// *** verilog/cbt_pkg.sv ***
// ****************************************************************************
// shared constants and types of the bus transceiver
// ****************************************************************************
package cbt_pkg;

    // ************************************************************************
    // phase counter: four clk cycles make one phase period
    // ************************************************************************
    localparam logic [1:0] CBT_CNT_STEP   = 2'h1;  // counter advance per clk
    localparam logic [1:0] CBT_PH_A_SLOT  = 2'h0;  // phase a high in this slot
    localparam logic [1:0] CBT_PH_B_SLOT  = 2'h2;  // phase b high in this slot
    localparam int         CBT_MCLK_BIT   = 0;     // counter bit that forms master clock

    // ************************************************************************
    // idle and reset levels
    // ************************************************************************
    localparam logic CBT_LANE_IDLE  = 1'h0;  // data lane flop idle level
    localparam logic CBT_GATE_IDLE  = 1'h0;  // gate flop idle level
    localparam logic CBT_DIR_RESET  = 1'h1;  // direction select idles in receive
    localparam logic CBT_CLR_RESET  = 1'h1;  // clear input idles negated

    // ************************************************************************
    // types
    // ************************************************************************
    // direction latch
    typedef enum logic {
        CBT_RECEIVE,
        CBT_TRANSMIT
    } cbt_mode_type;

    // spurious edge guard sequence
    typedef enum logic [1:0] {
        CBT_GUARD_IDLE,
        CBT_GUARD_ARMED,
        CBT_GUARD_FIRED,
        CBT_GUARD_RELEASE
    } cbt_guard_type;

    // link side state
    typedef struct packed {
        logic lane_a;  // lane a flop
        logic lane_b;  // lane b flop
        logic gate;    // bus clock gate flop
    } cbt_link_type;

endpackage : cbt_pkg

// *** verilog/cbt_link_rx.sv ***
`timescale 1ns/1ns
// ****************************************************************************
// receive flops on the link clock
// ****************************************************************************
module cbt_link_rx
    import cbt_pkg::*;
(
    // link clock and reset
    input  wire logic bus_shift_clk,
    input  wire logic rst_n,
    // bus lanes
    input  wire logic bus_lane_a_in,
    input  wire logic bus_lane_b_in,
    // captured state
    output logic      lane_a_flop,
    output logic      lane_b_flop,
    output logic      bus_clock_gate_flop
);

    cbt_link_type r;       // registered state
    cbt_link_type next_r;  // next state

    // ************************************************************************
    // next state: sample lanes, toggle gate
    // ************************************************************************
    always_comb begin
        next_r        = r;
        next_r.lane_a = bus_lane_a_in;
        next_r.lane_b = bus_lane_b_in;
        next_r.gate   = ~r.gate;
    end

    // ************************************************************************
    // falling shift clock edge registers the state
    // ************************************************************************
    always_ff @(negedge bus_shift_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{lane_a: CBT_LANE_IDLE, lane_b: CBT_LANE_IDLE, gate: CBT_GATE_IDLE};
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the flops
    assign lane_a_flop         = r.lane_a;
    assign lane_b_flop         = r.lane_b;
    assign bus_clock_gate_flop = r.gate;

endmodule : cbt_link_rx

// *** dv/cbt_transceiver_monitor.sv ***
`timescale 1ns/1ns
// ****************************************************************************
// port checker of the bus transceiver
// ****************************************************************************
module cbt_transceiver_monitor (
    // clock, reset and cpu controls
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clear_n,
    input wire logic dir_select,
    input wire logic dir_select_n,
    // cpu side pins
    input wire logic cpu_serial_lane_a_in,
    input wire logic cpu_xfer_clk_in,
    input wire logic cpu_xfer_clk_out,
    input wire logic cpu_xfer_clk_oe,
    // clocks made by the block
    input wire logic phase_a,
    input wire logic phase_b,
    input wire logic bus_master_clock_pair_out,
    // bus side pins
    input wire logic bus_lane_a_pair_out,
    input wire logic bus_lane_a_pair_oe,
    input wire logic bus_transfer_clock_pair_out
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_phase_order: assert property (phase_a |=> !phase_a && !phase_b ##1 phase_b && !phase_a ##1 !phase_b ##1 phase_a)
        else $error("phase clocks out of order");
    a_mclk_forward: assert property (1 |=> bus_master_clock_pair_out != $past(bus_master_clock_pair_out))
        else $error("master clock not forwarded");
    a_dir_inverse: assert property (dir_select_n == !$past(dir_select, 3))
        else $error("direction inverse wrong");
    a_tx_entry: assert property ($fell(dir_select) && clear_n |-> ##[3:6] bus_lane_a_pair_oe && !cpu_xfer_clk_oe)
        else $error("transmit mode not entered");
    a_rx_return: assert property ($rose(dir_select) && clear_n |-> ##[3:6] cpu_xfer_clk_oe && !bus_lane_a_pair_oe)
        else $error("receive mode not entered");
    a_clear_rx: assert property ((!clear_n && dir_select) [*6] |-> !cpu_xfer_clk_out && cpu_xfer_clk_oe)
        else $error("clear did not pull cpu clock low");
    a_spur_clear: assert property ($fell(cpu_xfer_clk_out) && cpu_xfer_clk_oe && clear_n |-> ##[1:24] cpu_xfer_clk_out)
        else $error("gate flop left set");
    a_tx_lane: assert property ((bus_lane_a_pair_oe && clear_n && $stable(cpu_serial_lane_a_in)) [*6]
        |-> bus_lane_a_pair_out == cpu_serial_lane_a_in)
        else $error("bus lane does not follow cpu lane");
    a_tx_clock: assert property ((bus_lane_a_pair_oe && clear_n && cpu_xfer_clk_in) [*6]
        |-> bus_transfer_clock_pair_out != $past(bus_transfer_clock_pair_out))
        else $error("bus clock not running");
endmodule : cbt_transceiver_monitor

bind cbt_transceiver cbt_transceiver_monitor u_monitor (.*);

// *** dv/cbt_peer_model.sv ***
`timescale 1ns/1ns
// ****************************************************************************
// far side transceiver on the bus
// ****************************************************************************
module cbt_peer_model (
    // link clock and lanes toward the block
    output logic      bus_shift_clk,
    output logic      bus_lane_a_pair_in,
    output logic      bus_lane_b_pair_in,
    // transmit side of the block
    input  wire logic bus_transfer_clock_pair_out,
    input  wire logic bus_lane_a_pair_out,
    input  wire logic bus_lane_b_pair_out
);
    logic got_a;  // lane a seen mid bit
    logic got_b;  // lane b seen mid bit

    // link clock stands high outside frames
    initial begin
        bus_shift_clk = 1'h1;
        bus_lane_a_pair_in = 1'h1;
        bus_lane_b_pair_in = 1'h1;
    end

    // sample on the falling bus clock, away from the lane update
    always @(negedge bus_transfer_clock_pair_out) begin
        got_a <= bus_lane_a_pair_out;
        got_b <= bus_lane_b_pair_out;
    end

    // one transition: one 6 ns link clock cycle, single ended lanes
    task automatic edge_out(input logic a, input logic b);
        bus_lane_a_pair_in = a;
        bus_lane_b_pair_in = b;
        #3 bus_shift_clk = 1'h0;
        #3 bus_shift_clk = 1'h1;
    endtask : edge_out

    // two transitions back to back, then lanes driven to the complement of the last pair
    task automatic send_pair(input logic a0, input logic b0, input logic a1, input logic b1);
        edge_out(a0, b0);
        edge_out(a1, b1);
        #3 bus_lane_a_pair_in = ~a1;
        bus_lane_b_pair_in = ~b1;
    endtask : send_pair
endmodule : cbt_peer_model

// *** dv/cbt_transceiver_tb_top.sv ***
`timescale 1ns/1ns
// ****************************************************************************
// bench of the bus transceiver
// ****************************************************************************
module cbt_transceiver_tb_top
    import cbt_pkg::*;
;
    logic clk, arst_n, clear_n, dir_select, dir_select_n, phase_a, phase_b;
    logic cpu_serial_lane_a_in, cpu_serial_lane_a_out, cpu_serial_lane_a_oe;
    logic cpu_serial_lane_b_in, cpu_serial_lane_b_out, cpu_serial_lane_b_oe;
    logic cpu_xfer_clk_in, cpu_xfer_clk_out, cpu_xfer_clk_oe;
    logic bus_master_clock_pair_out, bus_master_clock_pair_oe;
    logic bus_lane_a_pair_out, bus_lane_a_pair_oe, bus_lane_b_pair_out, bus_lane_b_pair_oe;
    logic bus_transfer_clock_pair_out, bus_transfer_clock_pair_oe;
    wire  bus_shift_clk, bus_lane_a_pair_in, bus_lane_b_pair_in;  // far side drives these
    int   error_cnt = 0;
    int   checks_done = 0;
    int   cycle_cnt = 0;

    cbt_transceiver dut (.*);
    cbt_peer_model peer (.*);

    // 20 MHz master clock
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    // cut a hang short
    always @(posedge clk) begin
        cycle_cnt++;
        if (cycle_cnt == 4000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic check_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic final_report();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // bounded wait for the cpu clock pin
    task automatic wait_cpu_clk(input logic lvl, input int n);
        for (int i = 0; i < n && cpu_xfer_clk_out !== lvl; i++) @(negedge clk);
    endtask : wait_cpu_clk

    // long transfer of five pairs, last pair carries the idle level
    task automatic test_rx();
        logic [4:0] pa;
        logic [4:0] pb;
        pa = {CBT_LANE_IDLE, 4'hD};
        pb = {CBT_LANE_IDLE, 4'hA};
        for (int p = 0; p < 5; p++) begin
            @(posedge clk);
            #7 peer.send_pair(~pa[p], ~pb[p], pa[p], pb[p]);
            repeat (6) @(posedge clk);
            check_bit("rx lane a", pa[p], cpu_serial_lane_a_out);
            check_bit("rx lane b", pb[p], cpu_serial_lane_b_out);
            check_bit("rx cpu clock", 1'h1, cpu_xfer_clk_out);
        end
    endtask : test_rx

    // single stray transition must not hold the cpu clock low
    task automatic test_spurious();
        @(posedge clk);
        #7 peer.edge_out(1'h1, 1'h1);
        wait_cpu_clk(1'h0, 12);
        check_bit("stray low", 1'h0, cpu_xfer_clk_out);
        wait_cpu_clk(1'h1, 30);
        check_bit("stray cleared", 1'h1, cpu_xfer_clk_out);
    endtask : test_spurious

    // five cpu clock pulses, ten half periods, last one idle
    task automatic test_tx();
        logic [9:0] pa;
        logic [9:0] pb;
        pa = 10'h0D9;
        pb = 10'h196;
        // previous scenario returns on a falling clk edge: realign to the rising edge
        @(posedge clk);
        dir_select <= 1'h0;
        repeat (8) @(posedge clk);
        check_bit("bus lane oe", 1'h1, bus_lane_b_pair_oe);
        check_bit("bus clock oe", 1'h1, bus_transfer_clock_pair_oe);
        check_bit("cpu lane oe", 1'h0, cpu_serial_lane_b_oe);
        check_bit("dir inverse", 1'h1, dir_select_n);
        for (int i = 0; i < 10; i++) begin
            cpu_serial_lane_a_in <= pa[i];
            cpu_serial_lane_b_in <= pb[i];
            cpu_xfer_clk_in <= ~i[0];
            repeat (6) @(posedge clk);
            check_bit("tx lane a", pa[i], peer.got_a);
            check_bit("tx lane b", pb[i], peer.got_b);
        end
        dir_select <= 1'h1;
        repeat (8) @(posedge clk);
        check_bit("cpu oe back", 1'h1, cpu_serial_lane_a_oe);
        check_bit("bus oe off", 1'h0, bus_master_clock_pair_oe ? bus_lane_a_pair_oe : 1'h1);
    endtask : test_tx

    // clear in receive, then in transmit until direction returns
    task automatic test_clear();
        clear_n <= 1'h0;
        repeat (6) @(posedge clk);
        check_bit("rx clear clock", 1'h0, cpu_xfer_clk_out);
        clear_n <= 1'h1;
        dir_select <= 1'h0;
        repeat (8) @(posedge clk);
        clear_n <= 1'h0;
        repeat (6) @(posedge clk);
        check_bit("tx clear oe", 1'h0, cpu_xfer_clk_oe);
        dir_select <= 1'h1;
        repeat (6) @(posedge clk);
        check_bit("late clear clock", 1'h0, cpu_xfer_clk_out);
        check_bit("late clear oe", 1'h1, cpu_xfer_clk_oe);
        clear_n <= 1'h1;
        repeat (6) @(posedge clk);
        check_bit("clock released", 1'h1, cpu_xfer_clk_out);
    endtask : test_clear

    // main sequence
    initial begin
        arst_n = 1'h0;
        clear_n = 1'h1;
        dir_select = 1'h1;
        cpu_serial_lane_a_in = 1'h0;
        cpu_serial_lane_b_in = 1'h0;
        cpu_xfer_clk_in = 1'h0;
        repeat (16) @(posedge clk);
        check_bit("reset phase a", 1'h1, phase_a);
        check_bit("reset mclk oe", 1'h1, bus_master_clock_pair_oe);
        check_bit("reset cpu oe", 1'h1, cpu_xfer_clk_oe);
        arst_n <= 1'h1;
        repeat (4) @(posedge clk);
        test_rx();
        test_spurious();
        test_tx();
        test_clear();
        final_report();
    end
endmodule : cbt_transceiver_tb_top
